// file: hw/dlsms_pkg.sv
// Purpose: shared constants and types for the dsp half-shift / mac-store datapath
// Assumes: one clock, synchronous active-low reset, 32-bit axi4-lite registers
// Notes:   register offsets are byte addresses of aligned words
package dlsms_pkg;

   localparam int unsigned DATA_W  = 32;
   localparam int unsigned HALF_W  = 16;
   localparam int unsigned GUARD_W = 8;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned NREG    = 8;

   // instruction encodings
   localparam logic [5:0] PREFIX_CODE  = 6'h3e;
   localparam logic [5:0] SHL_REG_TOP  = 6'h20;
   localparam logic [4:0] SHL_IMM_TOP  = 5'h00;
   localparam logic [2:0] STS_TOP      = 3'h6;
   localparam logic [1:0] STS_MID      = 2'h3;
   localparam logic [3:0] STS_ZERO     = 4'h0;
   localparam logic [1:0] COND_NONE    = 2'h1;
   localparam logic [1:0] COND_TRUE    = 2'h2;
   localparam logic [1:0] COND_FALSE   = 2'h3;
   localparam int unsigned CNT_DIR_BIT = 5;
   localparam int unsigned STS_LOW_BIT = 12;

   // register file indices selected by the destination field
   localparam logic [2:0] IDX_A0 = 3'h0;
   localparam logic [2:0] IDX_A1 = 3'h1;
   localparam logic [2:0] IDX_M0 = 3'h2;
   localparam logic [2:0] IDX_M1 = 3'h3;
   localparam logic [2:0] IDX_X0 = 3'h4;
   localparam logic [2:0] IDX_X1 = 3'h5;
   localparam logic [2:0] IDX_Y0 = 3'h6;
   localparam logic [2:0] IDX_Y1 = 3'h7;

   // register map
   localparam logic [ADDR_W-1:0] OFF_DREG   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_GUARD0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_GUARD1 = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_MAC_RESULT_HIGH   = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_MAC_RESULT_LOW   = 8'h2c;
   localparam logic [ADDR_W-1:0] OFF_DSR    = 8'h30;

   // status register layout
   localparam int unsigned DSR_DC  = 0;
   localparam int unsigned DSR_N   = 1;
   localparam int unsigned DSR_Z   = 2;
   localparam int unsigned DSR_V   = 3;
   localparam int unsigned DSR_GT  = 4;
   localparam int unsigned DSR_CS  = 5;
   localparam logic [7:0]  DSR_RST = 8'h00;
   localparam logic [2:0]  CS_CARRY = 3'h0;
   localparam logic [2:0]  CS_NEG   = 3'h1;
   localparam logic [2:0]  CS_ZERO  = 3'h2;
   localparam logic [2:0]  CS_OVF   = 3'h3;
   localparam logic [2:0]  CS_GT    = 3'h4;
   localparam logic [2:0]  CS_GE    = 3'h5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        valid;
      logic [15:0] prefix;
      logic [15:0] op;
      logic        paired;
   } dlsms_issue_s;

   typedef enum logic {EX_RUN, EX_PAIRED} dlsms_ex_e;

endpackage : dlsms_pkg

// file: hw/dlsms_half_shifter.sv
// Purpose: logical shift of a 16-bit half by a signed 6-bit count
// Assumes: counts beyond 16 either way are illegal; result then undefined
// Notes:   purely combinational
`timescale 1ns/1ps
module dlsms_half_shifter
   import dlsms_pkg::*;
(
   // operand
   input  wire logic [15:0] src_hw,
   input  wire logic [5:0]  cnt_field,
   // result
   output logic      [15:0] res_hw,
   output logic             carry
);
   logic [5:0]  right_cnt;
   logic [31:0] left_ext;
   logic [31:0] right_ext;

   always_comb begin
      // negative counts are two's complement; magnitude is ~f+1
      right_cnt = 6'({1'b0, ~cnt_field[4:0]}) + 6'h01;
      left_ext  = {16'h0000, src_hw} << cnt_field[4:0];
      right_ext = {src_hw, 16'h0000} >> right_cnt;
      // last bit shifted out lands just outside the kept half
      if (cnt_field[CNT_DIR_BIT]) begin
         res_hw = right_ext[31:16];
         carry  = right_ext[15];
      end else begin
         res_hw = left_ext[15:0];
         carry  = left_ext[16];
      end
   end

endmodule : dlsms_half_shifter

// file: hw/dlsms_core.sv
// Purpose: execute stage for the half-word logical shift and mac-store ops
// Assumes: decoder holds the issue word steady while stall is high
// Notes:   register file and status word reachable over axi4-lite
// Function
// RULE1 - shift only the upper half, write it upper, zero the lower half
// RULE2 - accumulator destinations also get their guard bits cleared
// RULE3 - non-negative count shifts left, negative shifts right with zero fill
// RULE4 - register count is bits 21..16 of source; bit 5 means right
// RULE5 - counts above 16 either way are illegal, result undefined
// RULE6 - carry is the last bit shifted out
// RULE7 - two-bit selects choose first source and count source
// RULE8 - immediate form shifts destination by signed immediate, always flags
// RULE9 - register form decoded from prefix 111110 and op byte 81/82/83
// RULE10 - conditional forms write only when condition flag matches, else nop
// RULE11 - conditional forms never touch any status flag
// RULE12 - unconditional shift updates condition flag by select and other flags
// RULE13 - negative is result msb, zero on zero half, overflow cleared
// RULE14 - store op copies high or low mac result into destination
// RULE15 - store op has if-true and if-false variants that gate the write
// RULE16 - store op never modifies any status flag
// RULE17 - store op paired with memory moves takes two cycles and stalls
// RULE18 - every other variant completes in one execute cycle
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module dlsms_core
   import dlsms_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // issue from decoder
   input  wire dlsms_issue_s      issue,
   output logic                   stall,
   output logic [7:0]             dsr_out,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready
);
   logic [NREG-1:0][31:0] dreg_reg;
   logic [1:0][7:0]       guard_reg;
   logic [31:0]           mac_result_high_reg;
   logic [31:0]           mac_result_low_reg;
   logic [7:0]            dsr_reg;
   dlsms_ex_e             state_reg;

   logic        pre_ok, is_shl_reg, is_shl_imm, is_shl, is_sts, uncond, cond_ok;
   logic        dc, exec_go, do_write, flags_upd, dz_ok, aw_take;
   logic [1:0]  cond;
   logic [2:0]  dz, sx_idx, sy_idx;
   logic [31:0] src_word, cnt_word, mac_word;
   logic [5:0]  cnt_field;
   logic [15:0] shift_res;
   logic        shift_carry, dc_next;
   logic [2:0]  cs;
   logic [31:0] rd_word;
   logic        rd_hit, wr_hit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   assign dc      = dsr_reg[DSR_DC];
   assign cs      = dsr_reg[DSR_CS +: 3];
   assign dsr_out = dsr_reg;

   // decode
   always_comb begin
      pre_ok     = issue.prefix[15:10] == PREFIX_CODE;
      is_shl_reg = pre_ok && issue.op[15:10] == SHL_REG_TOP && issue.op[9:8] != 2'h0;  // [RULE9]
      is_shl_imm = pre_ok && issue.op[15:11] == SHL_IMM_TOP;  // [RULE8]
      is_shl     = is_shl_reg || is_shl_imm;
      is_sts     = pre_ok && issue.op[15:13] == STS_TOP && issue.op[11:10] == STS_MID
                   && issue.op[9:8] != 2'h0 && issue.op[7:4] == STS_ZERO;  // [RULE14] [RULE15]
      cond       = issue.op[9:8];
      uncond     = is_shl_imm || cond == COND_NONE;
      // [RULE10] [RULE15]
      cond_ok    = uncond || (cond == COND_TRUE && dc) || (cond == COND_FALSE && !dc);
      dz         = issue.op[2:0];
      dz_ok      = !issue.op[3];
      mac_word   = issue.op[STS_LOW_BIT] ? mac_result_low_reg : mac_result_high_reg;
   end

   // operand selection
   always_comb begin
      unique case (issue.op[7:6])  // [RULE7]
         2'h0: sx_idx = IDX_X0;
         2'h1: sx_idx = IDX_X1;
         2'h2: sx_idx = IDX_A0;
         2'h3: sx_idx = IDX_A1;
      endcase
      unique case (issue.op[5:4])  // [RULE7]
         2'h0: sy_idx = IDX_Y0;
         2'h1: sy_idx = IDX_Y1;
         2'h2: sy_idx = IDX_M0;
         2'h3: sy_idx = IDX_M1;
      endcase
      cnt_word = dreg_reg[sy_idx];
      if (is_shl_imm) begin
         src_word  = dreg_reg[dz];  // [RULE8]
         cnt_field = issue.op[9:4];
      end else begin
         src_word  = dreg_reg[sx_idx];
         cnt_field = cnt_word[21:16];  // [RULE4]
      end
   end

   // [RULE3] [RULE5] [RULE6]
   dlsms_half_shifter u_shift (
      .src_hw    (src_word[31:16]),
      .cnt_field (cnt_field),
      .res_hw    (shift_res),
      .carry     (shift_carry)
   );

   // a paired store is held one extra cycle; all else finishes at once
   always_comb begin
      stall     = issue.valid && is_sts && issue.paired && state_reg == EX_RUN;  // [RULE17]
      exec_go   = issue.valid && !stall;  // [RULE18]
      do_write  = exec_go && (is_shl || is_sts) && cond_ok && dz_ok;
      flags_upd = exec_go && is_shl && uncond;  // [RULE11] [RULE16]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= EX_RUN;
      end else begin
         unique case (state_reg)
            EX_RUN:    if (stall) state_reg <= EX_PAIRED;  // [RULE17]
            EX_PAIRED: state_reg <= EX_RUN;
         endcase
      end
   end

   // condition flag source per select; gt and ge follow the half result
   always_comb begin
      unique case (cs)  // [RULE12]
         CS_CARRY: dc_next = shift_carry;
         CS_NEG:   dc_next = shift_res[15];
         CS_ZERO:  dc_next = shift_res == 16'h0000;
         CS_OVF:   dc_next = 1'b0;
         CS_GT:    dc_next = !shift_res[15] && shift_res != 16'h0000;
         CS_GE:    dc_next = !shift_res[15];
         default:  dc_next = 1'b0;
      endcase
   end

   // execution owns the register file in its cycle; bus writes wait
   assign aw_take = awvalid && wvalid && !bvalid && !do_write;
   assign awready = aw_take;
   assign wready  = aw_take;
   assign wr_hit  = awaddr[1:0] == 2'h0 && awaddr <= OFF_DSR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dreg_reg <= '0;
      end else if (do_write) begin
         if (is_shl) begin
            dreg_reg[dz] <= {shift_res, 16'h0000};  // [RULE1]
         end else begin
            dreg_reg[dz] <= mac_word;  // [RULE14]
         end
      end else if (aw_take && awaddr < OFF_GUARD0 && awaddr[1:0] == 2'h0) begin
         dreg_reg[awaddr[4:2]] <= merge(dreg_reg[awaddr[4:2]], wdata, wstrb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guard_reg <= '0;
      end else if (do_write && dz[2:1] == 2'h0) begin
         // store op sign-extends into the guard byte
         guard_reg[dz[0]] <= is_shl ? 8'h00 : {8{mac_word[31]}};  // [RULE2]
      end else if (aw_take && wstrb[0] && awaddr == OFF_GUARD0) begin
         guard_reg[0] <= wdata[7:0];
      end else if (aw_take && wstrb[0] && awaddr == OFF_GUARD1) begin
         guard_reg[1] <= wdata[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mac_result_high_reg <= '0;
         mac_result_low_reg <= '0;
      end else if (aw_take && awaddr == OFF_MAC_RESULT_HIGH) begin
         mac_result_high_reg <= merge(mac_result_high_reg, wdata, wstrb);
      end else if (aw_take && awaddr == OFF_MAC_RESULT_LOW) begin
         mac_result_low_reg <= merge(mac_result_low_reg, wdata, wstrb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dsr_reg <= DSR_RST;
      end else if (flags_upd) begin
         dsr_reg[DSR_DC] <= dc_next;  // [RULE12]
         dsr_reg[DSR_N]  <= shift_res[15];  // [RULE13]
         dsr_reg[DSR_Z]  <= shift_res == 16'h0000;
         dsr_reg[DSR_V]  <= 1'b0;
         dsr_reg[DSR_GT] <= !shift_res[15] && shift_res != 16'h0000;
      end else if (aw_take && wstrb[0] && awaddr == OFF_DSR) begin
         dsr_reg <= wdata[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (aw_take) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_hit  = araddr[1:0] == 2'h0;
      rd_word = 32'h0000_0000;
      if (araddr < OFF_GUARD0) begin
         rd_word = dreg_reg[araddr[4:2]];
      end else begin
         unique case (araddr)
            OFF_GUARD0: rd_word = {24'h000000, guard_reg[0]};
            OFF_GUARD1: rd_word = {24'h000000, guard_reg[1]};
            OFF_MAC_RESULT_HIGH:   rd_word = mac_result_high_reg;
            OFF_MAC_RESULT_LOW:   rd_word = mac_result_low_reg;
            OFF_DSR:    rd_word = {24'h000000, dsr_reg};
            default:    rd_hit  = 1'b0;
         endcase
      end
   end

   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata  <= rd_hit ? rd_word : 32'h0000_0000;
         rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // helper state for the checks below
   logic        chk_shl_reg, chk_sts_reg;
   logic [2:0]  chk_dz_reg;
   logic [15:0] chk_res_reg;
   logic [31:0] chk_mac_reg;

   always_ff @(posedge aclk) begin
      chk_shl_reg <= aresetn && do_write && is_shl;
      chk_sts_reg <= aresetn && do_write && is_sts;
      chk_dz_reg  <= dz;
      chk_res_reg <= shift_res;
      chk_mac_reg <= mac_word;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_shift_upper_half: assert property ( // [RULE1]
      chk_shl_reg |-> dreg_reg[chk_dz_reg] == {chk_res_reg, 16'h0000})
      else $error("shift result not in upper half with lower half zero");
   a_guard_cleared: assert property ( // [RULE2]
      chk_shl_reg && chk_dz_reg[2:1] == 2'h0 |-> guard_reg[chk_dz_reg[0]] == 8'h00)
      else $error("guard bits not cleared by shift");
   a_left_shift_val: assert property ( // [RULE3]
      is_shl && !cnt_field[5] && cnt_field[4:0] <= 5'd16
      |-> shift_res == 16'(src_word[31:16] << cnt_field[4:0]))
      else $error("left shift value wrong");
   a_right_count_reg: assert property ( // [RULE4]
      is_shl_reg && cnt_field == 6'h3e |-> shift_res == (src_word[31:16] >> 2))
      else $error("right shift by two from register count wrong");
   a_flag_values: assert property ( // [RULE13]
      flags_upd && !aw_take |=> !dsr_reg[DSR_V] && dsr_reg[DSR_N] == $past(shift_res[15])
                               && dsr_reg[DSR_Z] == ($past(shift_res) == 16'h0000))
      else $error("shift flags wrong");
   a_dc_from_carry: assert property ( // [RULE12]
      flags_upd && cs == CS_CARRY |=> dsr_reg[DSR_DC] == $past(shift_carry))
      else $error("condition flag not last shifted-out bit");
   a_cond_flags_hold: assert property ( // [RULE11]
      exec_go && is_shl && !uncond && !aw_take |=> $stable(dsr_reg))
      else $error("conditional shift changed flags");
   a_cond_nop: assert property ( // [RULE10]
      exec_go && (is_shl || is_sts) && !cond_ok && !aw_take |=> $stable(dreg_reg))
      else $error("failed condition still wrote destination");
   a_store_copy: assert property ( // [RULE14]
      chk_sts_reg |-> dreg_reg[chk_dz_reg] == chk_mac_reg)
      else $error("store did not copy mac result");
   a_store_flags: assert property ( // [RULE16]
      exec_go && is_sts && !aw_take |=> $stable(dsr_reg))
      else $error("store changed flags");
   a_paired_two: assert property ( // [RULE17]
      stall |=> state_reg == EX_PAIRED && !stall ##1 state_reg == EX_RUN)
      else $error("paired store not exactly two cycles");
   a_single_cycle: assert property ( // [RULE18]
      issue.valid && !(is_sts && issue.paired) && state_reg == EX_RUN
      |-> exec_go ##1 state_reg == EX_RUN)
      else $error("unpaired op stalled");

   c_paired_store: cover property (stall ##1 do_write);
   c_shift_write: cover property (do_write && is_shl && !uncond);
   c_cond_nop: cover property (exec_go && is_sts && !cond_ok);
   c_imm_shift: cover property (flags_upd && is_shl_imm && cnt_field[5]);

endmodule : dlsms_core

// file: tb/dlsms_decoder_model.sv
// Purpose: decoder-side model that issues instruction word pairs into the execute stage
// Assumes: caller enters a task just after a rising edge
// Notes:   released words show inverted bits so stale values cannot pass for live ones
`timescale 1ns/1ps
module dlsms_decoder_model
   import dlsms_pkg::*;
(
   // clock
   input  wire logic    aclk,
   // issue to execute stage
   output dlsms_issue_s issue,
   input  wire logic    stall
);
   initial issue = '0;

   // returns just after the take edge, with the word still up for back-to-back use
   task automatic send(input logic [15:0] prefix, input logic [15:0] op, input logic paired,
                       output int stalls);
      stalls = 0;
      issue <= '{valid: 1'b1, prefix: prefix, op: op, paired: paired};
      do begin
         @(negedge aclk);
         if (stall) stalls++;
      end while (stall); // word held unchanged while stalled
      @(posedge aclk);
   endtask : send

   task automatic release_issue();
      issue <= '{valid: 1'b0, prefix: ~issue.prefix, op: ~issue.op, paired: 1'b0};
   endtask : release_issue
endmodule : dlsms_decoder_model

// file: tb/tb_dsp_logical_shift_mac_store.sv
// Purpose: self-checking bench for the half-shift and mac-store execute stage
// Assumes: register file, mac words and status reached over axi4-lite
// Notes:   a shadow copy of all state is updated by bench functions; all but the mac words are compared
`timescale 1ns/1ps
module tb_dsp_logical_shift_mac_store import dlsms_pkg::*;;
   logic              aclk, aresetn, stall;
   dlsms_issue_s      issue;
   logic [7:0]        dsr_out, dsr_s;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [1:0]        bresp, rresp;
   int                failures, samples_checked;
   logic [31:0]       sh [8];
   logic [31:0]       mac [2];
   logic [7:0]        gd [2];
   localparam logic [2:0] XI [4] = '{IDX_X0, IDX_X1, IDX_A0, IDX_A1};
   localparam logic [2:0] YI [4] = '{IDX_Y0, IDX_Y1, IDX_M0, IDX_M1};

   dlsms_core dut (.aclk(aclk), .aresetn(aresetn), .issue(issue), .stall(stall),
      .dsr_out(dsr_out), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   dlsms_decoder_model dec (.aclk(aclk), .issue(issue), .stall(stall));

   task automatic end_of_test();
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge aclk); while (!(awready && wready));
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge aclk); while (!bvalid);
      chk(bresp, er);
      @(posedge aclk);
      if (er == RESP_OKAY) begin
         if (a < OFF_GUARD0) sh[a[4:2]] = d;
         else if (a == OFF_GUARD0) gd[0] = d[7:0];
         else if (a == OFF_GUARD1) gd[1] = d[7:0];
         else if (a == OFF_MAC_RESULT_HIGH) mac[0] = d;
         else if (a == OFF_MAC_RESULT_LOW) mac[1] = d;
         else dsr_s = d[7:0];
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge aclk);
   endtask : rd

   task automatic check_all();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4), d, r);
         chk(d, sh[i]);
      end
      rd(OFF_GUARD0, d, r);
      chk(d[7:0], gd[0]);
      rd(OFF_GUARD1, d, r);
      chk(d[7:0], gd[1]);
      rd(OFF_DSR, d, r);
      chk(d[7:0], dsr_s);
      chk(dsr_out, dsr_s);
   endtask : check_all

   // {carry, shifted half}
   function automatic logic [16:0] shl_ref(input logic [15:0] s, input logic [5:0] f);
      logic [4:0] c;
      if (!f[5]) begin
         c = f[4:0];
         return {(c == 5'h00) ? 1'b0 : s[16 - c], s << c};
      end
      c = ~f[4:0] + 5'h01;
      return {s[c - 1], s >> c};
   endfunction : shl_ref

   function automatic logic [7:0] dsr_ref(input logic [7:0] old, input logic [16:0] r);
      logic n, z, gt, dc;
      n = r[15];
      z = (r[15:0] == 16'h0000);
      gt = !n && !z;
      case (old[7:5])
         CS_CARRY: dc = r[16];
         CS_NEG:   dc = n;
         CS_ZERO:  dc = z;
         CS_GT:    dc = gt;
         CS_GE:    dc = !n;
         default:  dc = 1'b0;
      endcase
      return {old[7:5], gt, 1'b0, z, n, dc};
   endfunction : dsr_ref

   function automatic void model_op(input logic [15:0] p, input logic [15:0] op);
      logic [3:0]  dz;
      logic [1:0]  cc;
      logic        ex;
      logic [16:0] r;
      logic [31:0] v;
      dz = op[3:0];
      if (p[15:10] != PREFIX_CODE) return;
      if (op[15:10] == SHL_REG_TOP && op[9:8] != 2'h0) begin
         cc = op[9:8];
         r = shl_ref(sh[XI[op[7:6]]][31:16], sh[YI[op[5:4]]][21:16]);
      end else if (op[15:11] == SHL_IMM_TOP) begin
         cc = COND_NONE;
         r = shl_ref(sh[dz[2:0]][31:16], op[9:4]);
      end else if (op[15:13] == STS_TOP && op[11:10] == STS_MID && op[7:4] == STS_ZERO
                   && op[9:8] != 2'h0) begin
         cc = op[9:8];
         v = mac[op[12]];
      end else return;
      ex = (cc == COND_NONE) || (cc == COND_TRUE && dsr_s[DSR_DC])
           || (cc == COND_FALSE && !dsr_s[DSR_DC]);
      if (op[15:13] == STS_TOP) begin
         if (ex && !dz[3]) sh[dz[2:0]] = v;
         if (ex && dz < 4'h2) gd[dz[0]] = {8{v[31]}};
         return;
      end
      if (ex && !dz[3]) sh[dz[2:0]] = {r[15:0], 16'h0000};
      if (ex && dz < 4'h2) gd[dz[0]] = 8'h00;
      if (cc == COND_NONE) dsr_s = dsr_ref(dsr_s, r);
   endfunction : model_op

   function automatic logic [5:0] rand_count();
      int m;
      m = 1 + $urandom % 16;
      return ($urandom % 2) ? 6'(64 - m) : 6'(m);
   endfunction : rand_count

   task automatic run_one(input int kind, input logic [5:0] f, input logic [7:0] d0,
                          input logic pr, input logic [1:0] cc_in);
      logic [15:0] p, op;
      logic [1:0]  cc, xx, yy;
      logic [3:0]  dz;
      int          st;
      for (int i = 0; i < 8; i++) wr(8'(i * 4), $urandom, RESP_OKAY);
      wr(OFF_GUARD0, $urandom, RESP_OKAY);
      wr(OFF_GUARD1, $urandom, RESP_OKAY);
      wr(OFF_MAC_RESULT_HIGH, $urandom, RESP_OKAY);
      wr(OFF_MAC_RESULT_LOW, $urandom, RESP_OKAY);
      wr(OFF_DSR, {24'h0, d0}, RESP_OKAY);
      xx = 2'($urandom);
      yy = 2'($urandom);
      cc = (cc_in != 2'h0) ? cc_in : 2'(1 + $urandom % 3);
      dz = (kind == 1) ? 4'($urandom % 8) : 4'($urandom % 10);
      p = {PREFIX_CODE, 10'($urandom)};
      case (kind)
         0: begin
            op = {SHL_REG_TOP, cc, xx, yy, dz};
            // junk above and below the count field must be ignored
            wr({3'h0, YI[yy], 2'h0}, {10'($urandom), f, 16'($urandom)}, RESP_OKAY);
         end
         1: op = {SHL_IMM_TOP, f[5], f, dz};
         2: op = {STS_TOP, 1'($urandom), STS_MID, cc, STS_ZERO, dz};
         default: begin
            op = {SHL_REG_TOP, cc, xx, yy, dz};
            p[15:10] = ~PREFIX_CODE;
         end
      endcase
      model_op(p, op);
      dec.send(p, op, pr, st);
      dec.release_issue();
      chk(32'(st), {31'h0, pr});
      check_all();
   endtask : run_one

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      repeat (60000) @(posedge aclk);
      failures++;
      end_of_test();
   end

   initial begin
      int          st;
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] p;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      failures = 0;
      samples_checked = 0;
      void'($urandom(6));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) sh[i] = 32'h0;
      mac = '{32'h0, 32'h0};
      gd = '{8'h00, 8'h00};
      dsr_s = DSR_RST;
      check_all();
      run_one(0, 6'h10, 8'h00, 1'b0, COND_NONE);
      run_one(0, 6'h30, 8'h00, 1'b0, COND_NONE);
      run_one(1, 6'h00, 8'h40, 1'b0, COND_NONE);
      run_one(1, 6'h3f, 8'h00, 1'b0, COND_NONE);
      for (int i = 0; i < 8; i++) run_one(0, 6'h05, {3'(i), 5'h00}, 1'b0, COND_NONE);
      for (int i = 0; i < 8; i++)
         run_one(i[2] ? 0 : 2, 6'h3e, {7'h0, i[0]}, 1'b0, i[1] ? COND_FALSE : COND_TRUE);
      run_one(2, 6'h00, 8'($urandom), 1'b1, COND_NONE);
      // two immediate shifts back to back, second reads the first result
      wr(8'h04, 32'h5555_5555, RESP_OKAY);
      p = {PREFIX_CODE, 10'h000};
      model_op(p, {SHL_IMM_TOP, 7'h07, 4'h1});
      dec.send(p, {SHL_IMM_TOP, 7'h07, 4'h1}, 1'b0, st);
      model_op(p, {SHL_IMM_TOP, 7'h7d, 4'h1});
      dec.send(p, {SHL_IMM_TOP, 7'h7d, 4'h1}, 1'b0, st);
      dec.release_issue();
      check_all();
      rd(8'h40, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      rd(8'h02, d, r);
      chk(r, RESP_SLVERR);
      wr(8'h44, 32'hffff_ffff, RESP_SLVERR);
      check_all();
      repeat (40) run_one($urandom % 4, rand_count(), 8'($urandom), 1'b0, 2'h0);
      end_of_test();
   end
endmodule : tb_dsp_logical_shift_mac_store
